/* File: rtl/lbtc_pkg.sv */
package lbtc_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    // flash period grows in steps of this, each step has 256 slots
    localparam int unsigned PERIOD_STEP_NS  = 128_000_000;
    localparam int unsigned SLOT_CYC        = PERIOD_STEP_NS / 256 / CLK_PERIOD_NS;
    localparam int unsigned SHDN_TIME_US    = 600;
    localparam int unsigned SHDN_CYC        = SHDN_TIME_US * 1000 / CLK_PERIOD_NS;
    // ramp of 256 level steps; base times per code step and for code 0
    localparam int unsigned RAMP_STEP_NS    = 96_000_000;
    localparam int unsigned RAMP_MIN_NS     = 1_500_000;
    localparam logic [19:0] RAMP_UNIT8_CYC  = 20'(RAMP_STEP_NS / 256 / 8 / CLK_PERIOD_NS);
    localparam logic [19:0] RAMP_MIN_CYC    = 20'(RAMP_MIN_NS / 256 / CLK_PERIOD_NS);

    localparam logic [3:0] ADDR_RST_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_PERIOD      = 4'h1;
    localparam logic [3:0] ADDR_ON_ONE      = 4'h2;
    localparam logic [3:0] ADDR_ON_TWO      = 4'h3;
    localparam logic [3:0] ADDR_CHAN        = 4'h4;
    localparam logic [3:0] ADDR_RAMP        = 4'h5;
    localparam logic [3:0] ADDR_AUTO        = 4'h9;
    localparam logic [3:0] ADDR_STATUS      = 4'hA;

    localparam logic [7:0] RST_VAL          = 8'h00;
    localparam logic [7:0] AUTO_RST_VAL     = 8'h07;
    localparam int unsigned SCALE_LSB       = 5;
    localparam int unsigned LINEAR_BIT      = 7;
    localparam int unsigned ENABLE_BIT      = 6;
    localparam int unsigned AUTO_STARTED_BIT = 7;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ON  = 2'b01,
        MODE_T1  = 2'b10,
        MODE_T2  = 2'b11
    } lbtc_mode_t;

    typedef enum logic [1:0] {
        SCALE_X1   = 2'b00,
        SCALE_X2   = 2'b01,
        SCALE_X4   = 2'b10,
        SCALE_FAST = 2'b11
    } lbtc_scale_t;

    typedef enum logic {
        ST_AWAKE = 1'b0,
        ST_SLEEP = 1'b1
    } lbtc_pwr_t;

    typedef struct packed {
        logic       we;
        logic [3:0] addr;
        logic [7:0] data;
    } lbtc_wr_t;

    typedef struct packed {
        logic [7:0]  lvl;
        logic [19:0] cnt;
    } lbtc_tmr_st_t;
endpackage

/* File: rtl/lbtc_blink_timer.sv */
module lbtc_blink_timer (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  phase_i,
    input  wire logic [7:0]  on_code_i,
    input  wire logic [19:0] rise_cyc_i,
    input  wire logic [19:0] fall_cyc_i,
    output logic             on_o,
    output logic [7:0]       level_o
);
    lbtc_pkg::lbtc_tmr_st_t st_q;
    lbtc_pkg::lbtc_tmr_st_t st_d;

    assign on_o    = phase_i < on_code_i;
    assign level_o = st_q.lvl;

    always_comb begin
        st_d = st_q;
        if (on_o && st_q.lvl != 8'hFF) begin
            if (st_q.cnt + 20'h00001 >= rise_cyc_i) begin
                st_d.cnt = 20'h00000;
                st_d.lvl = st_q.lvl + 8'h01;
            end else begin
                st_d.cnt = st_q.cnt + 20'h00001;
            end
        // fall then dark to period end
        end else if (!on_o && st_q.lvl != 8'h00) begin
            if (st_q.cnt + 20'h00001 >= fall_cyc_i) begin
                st_d.cnt = 20'h00000;
                st_d.lvl = st_q.lvl - 8'h01;
            end else begin
                st_d.cnt = st_q.cnt + 20'h00001;
            end
        end else begin
            st_d.cnt = 20'h00000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    rise_only_on_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_q.lvl > $past(st_q.lvl) |-> $past(on_o))
        else $error("level rose outside on-interval");
    zero_code_dark_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        on_code_i == 8'h00 && st_q.lvl == 8'h00 |=> st_q.lvl == 8'h00)
        else $error("code zero gave light");
    full_code_on_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        on_code_i == 8'hFF && phase_i == 8'hFE |-> on_o)
        else $error("code 255 not on at slot 254");
    ramp_full_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(st_q.lvl == 8'hFF));
endmodule

/* File: rtl/lbtc_core.sv */
module lbtc_core #(
    parameter logic [19:0] SLOT_CYC = 20'(lbtc_pkg::SLOT_CYC),
    parameter logic [19:0] SHDN_CYC = 20'(lbtc_pkg::SHDN_CYC)
) (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_b_i,
    input  wire lbtc_pkg::lbtc_wr_t reg_wr_i,
    input  wire logic [3:0]         reg_rd_addr_i,
    input  wire logic               sda_i,
    input  wire logic               shutdown_cond_i,
    output logic [7:0]              reg_rd_data_o,
    output logic [2:0][7:0]         led_level_o,
    output logic                    sleep_o
);
    typedef struct packed {
        logic [7:0]          rst_ctrl;
        logic [7:0]          period;
        logic [7:0]          on_one;
        logic [7:0]          on_two;
        logic [7:0]          chan;
        logic [7:0]          ramp;
        logic [7:0]          auto_ctl;
        logic                sda_s1;
        logic                sda_s2;
        logic                sda_s3;
        logic [19:0]         slot_cnt;
        logic [7:0]          per_cnt;
        logic [7:0]          phase;
        logic [19:0]         shdn_cnt;
        lbtc_pkg::lbtc_pwr_t pwr;
        logic [2:0][7:0]     led;
        logic [7:0]          rdata;
    } lbtc_core_st_t;

    lbtc_core_st_t st_q;
    lbtc_core_st_t st_d;
    logic [1:0]    rst_sync_q;
    logic          rst_n;
    logic [7:0]    period_n;
    logic [19:0]   rise_cyc;
    logic [19:0]   fall_cyc;
    logic [1:0]    t_on;
    logic [1:0][7:0] t_lvl;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic [19:0] ramp_cyc(input logic [3:0] code, input logic [1:0] scale);
        logic [19:0] mult;
        mult = 20'h00008;
        case (lbtc_pkg::lbtc_scale_t'(scale))
            lbtc_pkg::SCALE_X1:   mult = 20'h00008;
            lbtc_pkg::SCALE_X2:   mult = 20'h00010;
            lbtc_pkg::SCALE_X4:   mult = 20'h00020;
            lbtc_pkg::SCALE_FAST: mult = 20'h00001;
            default:              mult = 20'h00008;
        endcase
        // code zero is the short fixed ramp
        if (code == 4'h0) begin
            return lbtc_pkg::RAMP_MIN_CYC;
        end
        return 20'(20'(code) * lbtc_pkg::RAMP_UNIT8_CYC * mult);
    endfunction

    // s curve: quadratic ease in and out, cheaper than a table
    function automatic logic [7:0] shape(input logic [7:0] lvl, input logic linear);
        logic [15:0] sq;
        logic [7:0]  inv;
        sq  = 16'h0000;
        inv = 8'hFF - lvl;
        if (linear) begin
            return lvl;
        end
        if (!lvl[7]) begin
            sq = 16'(lvl) * 16'(lvl);
            return sq[14:7];
        end
        sq = 16'(inv) * 16'(inv);
        return 8'hFF - sq[14:7];
    endfunction

    // period in 128 ms steps, code 1 jumps to three steps
    assign period_n = (st_q.period[6:0] == 7'h00) ? 8'h01 : 8'(st_q.period[6:0]) + 8'h02;
    // one scale field for both ramps
    assign rise_cyc = ramp_cyc(st_q.ramp[3:0], st_q.rst_ctrl[lbtc_pkg::SCALE_LSB +: 2]);
    assign fall_cyc = ramp_cyc(st_q.ramp[7:4], st_q.rst_ctrl[lbtc_pkg::SCALE_LSB +: 2]);

    // two timers on one shared phase
    lbtc_blink_timer u_timer_one (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n),
        .phase_i    (st_q.phase),
        .on_code_i  (st_q.on_one),
        .rise_cyc_i (rise_cyc),
        .fall_cyc_i (fall_cyc),
        .on_o       (t_on[0]),
        .level_o    (t_lvl[0])
    );
    lbtc_blink_timer u_timer_two (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n),
        .phase_i    (st_q.phase),
        .on_code_i  (st_q.on_two),
        .rise_cyc_i (rise_cyc),
        .fall_cyc_i (fall_cyc),
        .on_o       (t_on[1]),
        .level_o    (t_lvl[1])
    );

    always_comb begin
        lbtc_pkg::lbtc_mode_t mode;
        logic [7:0]           lvl;
        mode = lbtc_pkg::MODE_OFF;
        lvl  = 8'h00;
        st_d = st_q;
        // writes land whatever the enable state
        if (reg_wr_i.we) begin
            case (reg_wr_i.addr)
                lbtc_pkg::ADDR_RST_CTRL: st_d.rst_ctrl = reg_wr_i.data;
                lbtc_pkg::ADDR_PERIOD:   st_d.period   = reg_wr_i.data;
                lbtc_pkg::ADDR_ON_ONE:   st_d.on_one   = reg_wr_i.data;
                lbtc_pkg::ADDR_ON_TWO:   st_d.on_two   = reg_wr_i.data;
                lbtc_pkg::ADDR_CHAN:     st_d.chan     = reg_wr_i.data;
                lbtc_pkg::ADDR_RAMP:     st_d.ramp     = reg_wr_i.data;
                lbtc_pkg::ADDR_AUTO:     st_d.auto_ctl = {1'b0, reg_wr_i.data[6:0]};
                default:                 st_d.rdata    = st_q.rdata;
            endcase
        end
        case (reg_rd_addr_i)
            lbtc_pkg::ADDR_RST_CTRL: st_d.rdata = st_q.rst_ctrl;
            lbtc_pkg::ADDR_PERIOD:   st_d.rdata = st_q.period;
            lbtc_pkg::ADDR_ON_ONE:   st_d.rdata = st_q.on_one;
            lbtc_pkg::ADDR_ON_TWO:   st_d.rdata = st_q.on_two;
            lbtc_pkg::ADDR_CHAN:     st_d.rdata = st_q.chan;
            lbtc_pkg::ADDR_RAMP:     st_d.rdata = st_q.ramp;
            lbtc_pkg::ADDR_AUTO:     st_d.rdata = st_q.auto_ctl;
            lbtc_pkg::ADDR_STATUS:   st_d.rdata = {5'h00, st_q.pwr == lbtc_pkg::ST_SLEEP, t_on};
            default:                 st_d.rdata = 8'h00;
        endcase

        // free-running period, 256 phase steps each period, each step period_n slots long
        if (st_q.slot_cnt + 20'h00001 >= SLOT_CYC) begin
            st_d.slot_cnt = 20'h00000;
            if (st_q.per_cnt + 8'h01 >= period_n) begin
                st_d.per_cnt = 8'h00;
                st_d.phase   = st_q.phase + 8'h01;
            end else begin
                st_d.per_cnt = st_q.per_cnt + 8'h01;
            end
        end else begin
            st_d.slot_cnt = st_q.slot_cnt + 20'h00001;
        end

        st_d.sda_s1 = sda_i;
        st_d.sda_s2 = st_q.sda_s1;
        st_d.sda_s3 = st_q.sda_s2;
        // delay restarts on every SDA fall
        if (st_q.sda_s3 && !st_q.sda_s2) begin
            st_d.shdn_cnt = SHDN_CYC;
        end else if (st_q.shdn_cnt != 20'h00000) begin
            st_d.shdn_cnt = st_q.shdn_cnt - 20'h00001;
        end
        case (st_q.pwr)
            lbtc_pkg::ST_AWAKE: begin
                if (shutdown_cond_i && st_q.shdn_cnt == 20'h00001) begin
                    st_d.pwr = lbtc_pkg::ST_SLEEP;
                end
            end
            lbtc_pkg::ST_SLEEP: begin
                if (!shutdown_cond_i) begin
                    st_d.pwr = lbtc_pkg::ST_AWAKE;
                end
            end
            default: st_d.pwr = lbtc_pkg::ST_AWAKE;
        endcase

        for (int i = 0; i < 3; i++) begin
            mode = lbtc_pkg::lbtc_mode_t'(st_q.chan[2*i +: 2]);
            case (mode)
                lbtc_pkg::MODE_OFF: lvl = 8'h00;
                lbtc_pkg::MODE_ON:  lvl = 8'hFF;
                lbtc_pkg::MODE_T1:  lvl = shape(t_lvl[0], st_q.period[lbtc_pkg::LINEAR_BIT]);
                lbtc_pkg::MODE_T2:  lvl = shape(t_lvl[1], st_q.period[lbtc_pkg::LINEAR_BIT]);
                default:            lvl = 8'h00;
            endcase
            // gate by enable bit and sleep state, EN pin unused
            if (!st_q.chan[lbtc_pkg::ENABLE_BIT] || st_q.pwr == lbtc_pkg::ST_SLEEP) begin
                lvl = 8'h00;
            end
            st_d.led[i] = lvl;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            // enable bit and all else cleared, except auto_ctl which loads 8'h07
            st_q          <= '0;
            st_q.auto_ctl <= lbtc_pkg::AUTO_RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rd_data_o = st_q.rdata;
    assign led_level_o   = st_q.led;
    assign sleep_o       = st_q.pwr;

    dark_when_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !st_q.chan[lbtc_pkg::ENABLE_BIT] |=> led_level_o == '0)
        else $error("led lit with enable clear");
    enable_reset_a: assert property (@(posedge clk_sys_i)
        $rose(rst_n) |-> !st_q.chan[lbtc_pkg::ENABLE_BIT])
        else $error("enable not clear after reset");
    write_kept_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        reg_wr_i.we && reg_wr_i.addr == lbtc_pkg::ADDR_ON_ONE |=> st_q.on_one == $past(reg_wr_i.data))
        else $error("write not stored");
    mode_on_full_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.chan[6:0] == 7'h41 && !sleep_o |=> led_level_o[0] == 8'hFF && led_level_o[1] == 8'h00)
        else $error("always-on channel not full");
    // a longer count left from an earlier code drains at the next slot end
    period_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.period[6:0] == 7'h01 && st_q.per_cnt <= 8'h02 |=> st_q.per_cnt <= 8'h02)
        else $error("period slot count too long");
    shdn_delay_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        $rose(sleep_o) |-> $past(st_q.shdn_cnt) == 20'h00001 && $past(shutdown_cond_i))
        else $error("sleep entered at wrong time");
    scale_fast_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.rst_ctrl[6:5] == 2'b11 && st_q.ramp == 8'h11 |-> rise_cyc == 20'h001D4 && fall_cyc == 20'h001D4)
        else $error("fast scaling wrong");
    s_curve_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        !st_q.period[lbtc_pkg::LINEAR_BIT] && st_q.chan[1:0] == 2'b10 && st_q.chan[lbtc_pkg::ENABLE_BIT] && !sleep_o
        && t_lvl[0] != 8'h00 && !t_lvl[0][7] |=> led_level_o[0] < $past(t_lvl[0]))
        else $error("s curve not below linear in lower half");
    linear_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.period[7] && st_q.chan[6:0] == 7'h42 && !sleep_o |=> led_level_o[0] == $past(t_lvl[0]))
        else $error("linear ramp altered");
    sleep_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n) $rose(sleep_o));
    t2_lit_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.chan[5:4] == 2'b11 && led_level_o[2] == 8'hFF);
    phase_wrap_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        st_q.phase == 8'hFF ##1 st_q.phase == 8'h00);
endmodule

/* File: dv/lbtc_host_model.sv */
module lbtc_host_model (
    input  wire logic               clk_sys_i,
    input  wire lbtc_pkg::lbtc_wr_t req_i,
    input  wire logic               sda_pulse_i,
    output lbtc_pkg::lbtc_wr_t      reg_wr_o,
    output logic                    sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0] low_q = 3'h0;

    always_comb begin
        reg_wr_o = req_i;
        if (req_i.addr == lbtc_pkg::ADDR_RST_CTRL) begin
            reg_wr_o.data[7] = 1'b0;
        end
    end

    // line has a pull-up: idle high, one falling edge per pulse
    always_ff @(posedge clk_sys_i) begin
        if (sda_pulse_i) begin
            low_q <= 3'h4;
        end else if (low_q != 3'h0) begin
            low_q <= low_q - 3'h1;
        end
    end
    assign sda_o = (low_q == 3'h0);
endmodule

/* File: dv/tb_led_blink_timing_control.sv */
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %0t got %0h expected %0h", $time, (got), (exp)); end end

module tb_led_blink_timing_control;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [19:0] SLOT = 20'h4;
    localparam logic [19:0] SHDN = 20'h14;

    logic               clk_sys_i = 1'b0;
    logic               rst_b_i   = 1'b0;
    lbtc_pkg::lbtc_wr_t req       = '0;
    lbtc_pkg::lbtc_wr_t wr;
    logic               sda_pulse = 1'b0;
    logic               sda;
    logic [3:0]         rd_addr   = 4'h0;
    logic               cond      = 1'b0;
    logic [7:0]         rd_data;
    logic [2:0][7:0]    led;
    logic               sleep;
    int                 mismatches = 0;
    int                 checks     = 0;
    logic [31:0]        seed       = 32'd75949;
    logic [7:0]         v, v2, lv;
    int                 n, c1, c2, per;

    initial forever #50 clk_sys_i = ~clk_sys_i;

    lbtc_host_model i_host (.clk_sys_i(clk_sys_i), .req_i(req), .sda_pulse_i(sda_pulse), .reg_wr_o(wr), .sda_o(sda));

    lbtc_core #(.SLOT_CYC(SLOT), .SHDN_CYC(SHDN)) i_dut (
        .clk_sys_i      (clk_sys_i),
        .rst_b_i        (rst_b_i),
        .reg_wr_i       (wr),
        .reg_rd_addr_i  (rd_addr),
        .sda_i          (sda),
        .shutdown_cond_i(cond),
        .reg_rd_data_o  (rd_data),
        .led_level_o    (led),
        .sleep_o        (sleep)
    );

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic int per_cyc(input int code);
        return 256 * SLOT * ((code == 0) ? 1 : code + 2);
    endfunction

    function automatic int ramp_cyc(input int code, input int scale);
        int m[4] = '{8, 16, 32, 1};
        return (code == 0) ? int'(lbtc_pkg::RAMP_MIN_CYC) : code * int'(lbtc_pkg::RAMP_UNIT8_CYC) * m[scale];
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic timed_out();
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        end_sim();
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{we: 1'b1, addr: a, data: d};
        @(posedge clk_sys_i);
        req.we <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_addr <= a;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        d = rd_data;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        // reset values, unmapped indexes read zero
        for (int a = 0; a < 16; a++) begin
            rd_reg(4'(a), v);
            `CHK(v, (a == 9) ? 8'h07 : 8'h00)
        end
        $display("test reset values done");

        // stored writes, refused bits, dark while disabled
        for (int k = 0; k < 6; k++) begin
            v = rnd8();
            wr_reg(4'h1, v); rd_reg(4'h1, v2); `CHK(v2, v)
            wr_reg(4'h2, v); rd_reg(4'h2, v2); `CHK(v2, v)
            wr_reg(4'h5, v); rd_reg(4'h5, v2); `CHK(v2, v)
            wr_reg(4'h9, v); rd_reg(4'h9, v2); `CHK(v2, v & 8'h7F)
            wr_reg(4'h7, v); rd_reg(4'h7, v2); `CHK(v2, 8'h00)
            wr_reg(4'h4, v & 8'h3F); rd_reg(4'h4, v2); `CHK(v2, v & 8'h3F)
            `CHK(led, 24'h000000)
        end
        wr_reg(4'h0, 8'hE0); rd_reg(4'h0, v2); `CHK(v2[7:5], 3'b011)
        $display("test register store done");

        // static modes and field placement
        for (int i = 0; i < 3; i++) begin
            for (int m = 0; m < 2; m++) begin
                wr_reg(4'h4, 8'h40 | 8'(m << (2 * i)));
                settle();
                for (int j = 0; j < 3; j++) begin
                    `CHK(led[j], (j == i && m == 1) ? 8'hFF : 8'h00)
                end
            end
        end
        wr_reg(4'h4, 8'h55); settle(); `CHK(led, 24'hFFFFFF)
        wr_reg(4'h4, 8'h15); settle(); `CHK(led, 24'h000000)
        $display("test channel modes done");

        // on-interval as share of period, both timers
        wr_reg(4'h4, 8'h4E);
        for (int t = 0; t < 3; t++) begin
            v  = (t == 0) ? 8'h80 : (t == 1) ? 8'h01 : rnd8();
            v2 = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : rnd8();
            wr_reg(4'h1, 8'(t));
            wr_reg(4'h2, v);
            wr_reg(4'h3, v2);
            per = per_cyc(t);
            rd_addr <= 4'hA;
            repeat (per) @(posedge clk_sys_i);
            c1 = 0;
            c2 = 0;
            repeat (2 * per) begin
                @(negedge clk_sys_i);
                c1 += rd_data[0];
                c2 += rd_data[1];
            end
            `CHK(c1, 2 * per * v / 256)
            `CHK(c2, 2 * per * v2 / 256)
        end
        $display("test on-interval done");

        // mid-run reset: LEDs dark, chan and auto registers read back their reset values
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd_reg(4'h4, v); `CHK(v, 8'h00)
        rd_reg(4'h9, v); `CHK(v, 8'h07)
        `CHK(led, 24'h000000)
        $display("test mid-run reset done");

        // ramp step length for each scale
        wr_reg(4'h1, 8'hFF);
        wr_reg(4'h2, 8'hFF);
        wr_reg(4'h5, 8'h11);
        wr_reg(4'h4, 8'h42);
        for (int s = 0; s < 4; s++) begin
            wr_reg(4'h0, 8'(s << 5));
            per = ramp_cyc(1, s);
            for (int e = 0; e < 2; e++) begin
                @(negedge clk_sys_i);
                lv = led[0];
                n = 0;
                while (led[0] === lv) begin
                    @(negedge clk_sys_i);
                    n++;
                    if (n > 2 * per + 100) timed_out();
                end
            end
            `CHK(led[0], lv + 8'h01)
            `CHK((n >= per - 1) && (n <= per + 1), 1'b1)
        end
        $display("test ramp scaling done");

        // shutdown delay after last falling edge
        wr_reg(4'h4, 8'h41);
        for (int k = 0; k < 2; k++) begin
            cond <= (k == 1);
            @(posedge clk_sys_i);
            sda_pulse <= 1'b1;
            @(posedge clk_sys_i);
            sda_pulse <= 1'b0;
            n = 0;
            while (sleep !== 1'b1 && n < 3 * SHDN) begin
                @(negedge clk_sys_i);
                n++;
            end
            `CHK(sleep, 1'(k))
            if (k == 1) begin
                `CHK((n >= SHDN) && (n <= SHDN + 6), 1'b1)
                // led output follows the sleep state one cycle later
                @(negedge clk_sys_i);
                `CHK(led[0], 8'h00)
            end
        end
        rd_reg(4'hA, v); `CHK(v[2], 1'b1)
        @(posedge clk_sys_i);
        cond <= 1'b0;
        settle();
        `CHK(sleep, 1'b0)
        `CHK(led[0], 8'hFF)
        $display("test shutdown done");
        end_sim();
    end
endmodule
